// file: usu_pkg.sv
`default_nettype none
package usu_pkg;
	localparam int NUM_UNITS = 2;
	typedef logic [7:0] usu_idx_type;
	// register indices; byte address is four times the index
	localparam usu_idx_type CSR_IDX  [NUM_UNITS] = '{8'h86, 8'hf8};
	localparam usu_idx_type DBUF_IDX [NUM_UNITS] = '{8'hc1, 8'hf9};
	localparam usu_idx_type BAUD_IDX [NUM_UNITS] = '{8'hc2, 8'hfa};
	localparam usu_idx_type UCR_IDX  [NUM_UNITS] = '{8'hc4, 8'hfb};
	localparam usu_idx_type GCR_IDX  [NUM_UNITS] = '{8'hc5, 8'hfc};
	localparam int CSR_MODE_BIT  = 7;
	localparam int CSR_RXON_BIT  = 6;
	localparam int CSR_SLAVE_BIT = 5;
	localparam int CSR_FE_BIT    = 4;
	localparam int CSR_PE_BIT    = 3;
	localparam int CSR_RXR_BIT   = 2;
	localparam int CSR_TXD_BIT   = 1;
	localparam int UCR_FLUSH_BIT = 7;
	localparam int UCR_FLOW_BIT  = 6;
	localparam int UCR_D9_BIT    = 5;
	localparam int UCR_NINE_BIT  = 4;
	localparam int UCR_PAR_BIT   = 3;
	localparam int UCR_SPB_BIT   = 2;
	localparam int UCR_STOP_BIT  = 1;
	localparam int UCR_START_BIT = 0;
	localparam int GCR_CPOL_BIT  = 7;
	localparam int GCR_CPHA_BIT  = 6;
	localparam int GCR_ORDER_BIT = 5;
	localparam int GCR_EXP_HI    = 4;
	localparam logic [6:0] UCR_RESET  = 7'h02;
	localparam logic [7:0] GCR_RESET  = 8'h00;
	localparam logic [7:0] BAUD_RESET = 8'h00;
	localparam logic [7:0] DBUF_RESET = 8'h00;
	// {ssN, miso, mosi, sck, ctsN, rxd} after reset
	localparam logic [5:0] SYNC_INIT  = 6'h23;
	localparam logic [2:0] UART_OVS_SHIFT = 3'h4;
	localparam logic [2:0] SPI_HALF_SHIFT = 3'h1;
	localparam logic [3:0] OVS_LAST  = 4'hf;
	localparam logic [3:0] OVS_MID   = 4'h7;
	localparam logic [3:0] BIT_LAST  = 4'h7;
	localparam logic [3:0] EDGE_LAST = 4'hf;
	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_START = 3'b001,
		TX_DATA  = 3'b011,
		TX_NINTH = 3'b010,
		TX_STOP  = 3'b110,
		TX_SPI   = 3'b100
	} usu_tx_state_type;
	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_BITS  = 2'b11,
		RX_STOP  = 2'b10
	} usu_rx_state_type;
endpackage : usu_pkg
`default_nettype wire

// file: usu_sync.sv
`timescale 1ns/10ps
`default_nettype none
module usu_sync #(
	parameter int         W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         mclk,
	input  wire logic         reset,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] stage1Reg;
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			stage1Reg <= INIT;
			dout      <= INIT;
		end
		else
		begin
			stage1Reg <= din;
			dout      <= stage1Reg;
		end
	end
endmodule : usu_sync
`default_nettype wire

// file: usu_rate.sv
`timescale 1ns/10ps
`default_nettype none
module usu_rate (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic [7:0] mant,
	input  wire logic [4:0] expo,
	input  wire logic [2:0] shift,
	input  wire logic       run,
	output logic            tick
);
	logic [27:0] accReg;
	logic [47:0] inc;
	logic [48:0] sum;
	logic [5:0]  amount;
	// tick rate = (256+mant)*2^(expo+shift)/2^28 of the clock
	assign amount = {1'b0, expo} + {3'h0, shift};
	assign inc    = {39'h0, 1'b1, mant} << amount;
	assign sum    = {21'h0, accReg} + {1'b0, inc};
	always_ff @(posedge mclk)
	begin
		if (reset | ~run)
		begin
			accReg <= 28'h0;
			tick   <= 1'b0;
		end
		else
		begin
			// rates above one tick a clock saturate
			accReg <= sum[27:0];
			tick   <= |sum[48:28];
		end
	end
endmodule : usu_rate
`default_nettype wire

// file: usu_top.sv
// Behaviour
// - mode bit 7 picks SPI or UART
// - UART receiver runs only when rx_on set
// - bit 5 picks SPI master or slave
// - bad stop level sets framing_error_flag
// - failed parity sets parity error flag
// - received byte sets ready flag, UART/slave
// - sent byte sets done flag, UART/master
// - busy bit shows transfer in progress
// - flush aborts unit, reads back zero
// - flow bit enables RTS/CTS handshaking
// - ninth_bit_value sent as ninth bit
// - ninth_bit_value selects even/odd parity
// - nine_bit_enable selects 8 or 9 bits
// - parity bit only when parity enabled
// - two_stop_select gives one or two stops
// - stop level from bit 1, reset high
// - start level bit 0, idle is opposite
// - generic bit 7 sets clock polarity
// - generic bit 6 sets clock phase
// - bit 5 picks LSB or MSB first
// - exponent and mantissa set the rate
// - data write loads tx, read gives rx
// - rate is (256+M)*2^E/2^28 of clock
`timescale 1ns/10ps
`default_nettype none
module usu_top
	import usu_pkg::*;
(
	input  wire logic                 mclk,
	input  wire logic                 reset,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [9:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	output logic      [NUM_UNITS-1:0] uartTxd,
	input  wire logic [NUM_UNITS-1:0] uartRxd,
	input  wire logic [NUM_UNITS-1:0] ctsN,
	output logic      [NUM_UNITS-1:0] rtsN,
	input  wire logic [NUM_UNITS-1:0] sckIn,
	output logic      [NUM_UNITS-1:0] sckOut,
	output logic      [NUM_UNITS-1:0] sckOeN,
	input  wire logic [NUM_UNITS-1:0] mosiIn,
	output logic      [NUM_UNITS-1:0] mosiOut,
	output logic      [NUM_UNITS-1:0] mosiOeN,
	input  wire logic [NUM_UNITS-1:0] misoIn,
	output logic      [NUM_UNITS-1:0] misoOut,
	output logic      [NUM_UNITS-1:0] misoOeN,
	input  wire logic [NUM_UNITS-1:0] ssN
);
	function automatic logic [7:0] usu_shift(input logic [7:0] v,
		input logic msb, input logic inb);
		return msb ? {v[6:0], inb} : {inb, v[7:1]};
	endfunction : usu_shift
	function automatic logic usu_first(input logic [7:0] v,
		input logic msb);
		return msb ? v[7] : v[0];
	endfunction : usu_first

	logic                 rdyReg;
	logic [31:0]          prdataReg;
	logic                 errReg;
	logic                 access;
	logic                 wrEn;
	logic [7:0]           idx;
	logic                 idxOk;
	logic [7:0]           unitRd [NUM_UNITS];
	logic [NUM_UNITS-1:0] unitHit;
	logic [7:0]           rdSel;
	logic                 hitSel;

	// one wait state so read data leaves a flip-flop
	assign access  = psel & penable;
	assign wrEn    = access & pwrite & rdyReg;
	assign idx     = paddr[9:2];
	assign idxOk   = paddr[1:0] == 2'b00;
	assign pready  = rdyReg;
	assign prdata  = prdataReg;
	assign pslverr = errReg & rdyReg;

	always_comb
	begin
		rdSel  = 8'h00;
		hitSel = 1'b0;
		for (int i = 0; i < NUM_UNITS; i++)
		begin
			if (unitHit[i])
				rdSel = unitRd[i];
			hitSel = hitSel | unitHit[i];
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			rdyReg    <= 1'b0;
			prdataReg <= 32'h0;
			errReg    <= 1'b0;
		end
		else
		begin
			rdyReg <= access & ~rdyReg;
			if (access & ~rdyReg)
			begin
				prdataReg <= {24'h0, rdSel};
				errReg    <= ~hitSel;
			end
		end
	end

	for (genvar g = 0; g < NUM_UNITS; g++)
	begin : unit
		logic hitCsr, hitDbuf, hitBaud, hitUcr, hitGcr;
		logic wrCsr, wrDbuf, wrUcr, flush;
		logic modeReg, rxOnReg, slaveReg;
		logic feReg, peReg, rxrReg, txdReg;
		logic [6:0] ucrReg;
		logic [7:0] gcrReg, baudReg, txDataReg, rxDataReg;
		logic [5:0] syncOut;
		logic rxS, ctsS, sckS, mosiS, misoS, ssS;
		logic flow, d9, nine, parEn, two_stop_select, stopLvl, startLvl;
		logic cpol, cpha, msb, ninthOn, tick, busy, slvBusy;
		usu_tx_state_type txState;
		usu_rx_state_type rxState;
		logic txPend, txLine, sckReg, mosiReg, ninthReg;
		logic [7:0] txShift, mShift, mByte;
		logic [3:0] sub, cnt;
		logic txDoneEv, mDoneEv;
		logic [3:0] rxSub, rxCnt;
		logic [7:0] rxSh, rxByte;
		logic rx9, rxDoneEv, feEv, peEv;
		logic sckPrev, ssPrev, misoReg, sDoneEv;
		logic [2:0] sCnt;
		logic [7:0] slvTx, slvRx, sByte;
		logic sckEdge, lead;

		assign hitCsr  = idxOk & (idx == CSR_IDX[g]);
		assign hitDbuf = idxOk & (idx == DBUF_IDX[g]);
		assign hitBaud = idxOk & (idx == BAUD_IDX[g]);
		assign hitUcr  = idxOk & (idx == UCR_IDX[g]);
		assign hitGcr  = idxOk & (idx == GCR_IDX[g]);
		assign unitHit[g] = hitCsr | hitDbuf | hitBaud | hitUcr | hitGcr;
		assign wrCsr  = wrEn & hitCsr;
		assign wrDbuf = wrEn & hitDbuf;
		assign wrUcr  = wrEn & hitUcr;
		assign flush  = wrUcr & pwdata[UCR_FLUSH_BIT];
		assign unitRd[g] = hitCsr ? {modeReg, rxOnReg, slaveReg, feReg,
			peReg, rxrReg, txdReg, busy} :
			hitUcr  ? {1'b0, ucrReg} :
			hitGcr  ? gcrReg :
			hitBaud ? baudReg :
			hitDbuf ? rxDataReg : 8'h00;

		assign flow     = ucrReg[UCR_FLOW_BIT];
		assign d9       = ucrReg[UCR_D9_BIT];
		assign nine     = ucrReg[UCR_NINE_BIT];
		assign parEn    = ucrReg[UCR_PAR_BIT];
		assign two_stop_select      = ucrReg[UCR_SPB_BIT];
		assign stopLvl  = ucrReg[UCR_STOP_BIT];
		assign startLvl = ucrReg[UCR_START_BIT];
		assign ninthOn  = nine | parEn;
		assign cpol     = gcrReg[GCR_CPOL_BIT];
		assign cpha     = gcrReg[GCR_CPHA_BIT];
		assign msb      = gcrReg[GCR_ORDER_BIT];
		assign {ssS, misoS, mosiS, sckS, ctsS, rxS} = syncOut;

		always_ff @(posedge mclk)
		begin
			if (reset)
			begin
				modeReg   <= 1'b0;
				rxOnReg   <= 1'b0;
				slaveReg  <= 1'b0;
				ucrReg    <= UCR_RESET;
				gcrReg    <= GCR_RESET;
				baudReg   <= BAUD_RESET;
				txDataReg <= DBUF_RESET;
			end
			else
			begin
				if (wrCsr)
				begin
					modeReg  <= pwdata[CSR_MODE_BIT];
					rxOnReg  <= pwdata[CSR_RXON_BIT];
					slaveReg <= pwdata[CSR_SLAVE_BIT];
				end
				if (wrUcr)
					ucrReg <= pwdata[6:0];
				if (wrEn & hitGcr)
					gcrReg <= pwdata[7:0];
				if (wrEn & hitBaud)
					baudReg <= pwdata[7:0];
				if (flush)
					txDataReg <= DBUF_RESET;
				else if (wrDbuf)
					txDataReg <= pwdata[7:0];
			end
		end

		usu_sync #(.W(6), .INIT(SYNC_INIT)) pinSync (
			.mclk  (mclk),
			.reset (reset),
			.din   ({ssN[g], misoIn[g], mosiIn[g], sckIn[g], ctsN[g],
				uartRxd[g]}),
			.dout  (syncOut)
		);

		// UART ticks at 16x bit rate, SPI at each half period
		usu_rate rateGen (
			.mclk  (mclk),
			.reset (reset | flush),
			.mant  (baudReg),
			.expo  (gcrReg[GCR_EXP_HI:0]),
			.shift (modeReg ? UART_OVS_SHIFT : SPI_HALF_SHIFT),
			.run   (modeReg | (txState == TX_SPI)),
			.tick  (tick)
		);

		always_ff @(posedge mclk)
		begin
			txDoneEv <= 1'b0;
			mDoneEv  <= 1'b0;
			if (reset | flush)
			begin
				txState  <= TX_IDLE;
				txPend   <= 1'b0;
				txLine   <= 1'b1;
				sckReg   <= 1'b0;
				mosiReg  <= 1'b0;
				ninthReg <= 1'b0;
				txShift  <= 8'h00;
				mShift   <= 8'h00;
				mByte    <= 8'h00;
				sub      <= 4'h0;
				cnt      <= 4'h0;
			end
			else
			begin
				case (txState)
				TX_IDLE:
				begin
					txLine <= ~startLvl;
					sckReg <= cpol;
					sub    <= 4'h0;
					cnt    <= 4'h0;
					// without flow control CTS is ignored
					if (txPend & modeReg & (~flow | ~ctsS))
					begin
						txState  <= TX_START;
						txLine   <= startLvl;
						txShift  <= txDataReg;
						txPend   <= 1'b0;
						ninthReg <= parEn ? (^txDataReg ^ d9) : d9;
					end
					else if (txPend & ~modeReg & ~slaveReg)
					begin
						txState <= TX_SPI;
						txPend  <= 1'b0;
						if (cpha)
							txShift <= txDataReg;
						else
						begin
							mosiReg <= usu_first(txDataReg, msb);
							txShift <= usu_shift(txDataReg, msb, 1'b0);
						end
					end
				end
				TX_START, TX_DATA, TX_NINTH, TX_STOP:
				begin
					if (tick)
						sub <= sub + 4'h1;
					if (tick & (sub == OVS_LAST))
					begin
						if (txState == TX_START)
						begin
							txState <= TX_DATA;
							txLine  <= usu_first(txShift, msb);
						end
						else if (txState == TX_DATA)
						begin
							cnt     <= cnt + 4'h1;
							txShift <= usu_shift(txShift, msb, 1'b0);
							txLine  <= usu_first(usu_shift(txShift, msb,
								1'b0), msb);
							if (cnt == BIT_LAST)
							begin
								cnt     <= 4'h0;
								txState <= ninthOn ? TX_NINTH : TX_STOP;
								txLine  <= ninthOn ? ninthReg : stopLvl;
							end
						end
						else if (txState == TX_NINTH)
						begin
							txState <= TX_STOP;
							txLine  <= stopLvl;
						end
						else if (two_stop_select & (cnt == 4'h0))
							cnt <= 4'h1;
						else
						begin
							txState  <= TX_IDLE;
							txLine   <= ~startLvl;
							txDoneEv <= 1'b1;
						end
					end
				end
				TX_SPI:
				begin
					if (tick)
					begin
						cnt    <= cnt + 4'h1;
						sckReg <= ~sckReg;
						// even edges leave the idle level
						if (~cnt[0] ^ cpha)
							mShift <= usu_shift(mShift, msb, misoS);
						else if (cnt != EDGE_LAST)
						begin
							mosiReg <= usu_first(txShift, msb);
							txShift <= usu_shift(txShift, msb, 1'b0);
						end
						if (cnt == EDGE_LAST)
						begin
							txState <= TX_IDLE;
							mDoneEv <= 1'b1;
							mByte   <= cpha ? usu_shift(mShift, msb, misoS)
								: mShift;
						end
					end
				end
				default:
					txState <= TX_IDLE;
				endcase
				if (wrDbuf)
					txPend <= 1'b1;
			end
		end

		always_ff @(posedge mclk)
		begin
			rxDoneEv <= 1'b0;
			feEv     <= 1'b0;
			peEv     <= 1'b0;
			if (reset | flush | ~modeReg | ~rxOnReg)
			begin
				rxState <= RX_IDLE;
				rxSub   <= 4'h0;
				rxCnt   <= 4'h0;
				rxSh    <= 8'h00;
				rx9     <= 1'b0;
				rxByte  <= 8'h00;
			end
			else
			begin
				if (tick)
					rxSub <= rxSub + 4'h1;
				case (rxState)
				RX_IDLE:
				begin
					rxSub <= 4'h0;
					rxCnt <= 4'h0;
					if (rxS == startLvl)
						rxState <= RX_START;
				end
				RX_START:
				begin
					// glitches shorter than half a bit are dropped
					if (tick & (rxSub == OVS_MID))
					begin
						rxSub   <= 4'h0;
						rxState <= (rxS == startLvl) ? RX_BITS : RX_IDLE;
					end
				end
				RX_BITS:
				begin
					if (tick & (rxSub == OVS_LAST))
					begin
						rxCnt <= rxCnt + 4'h1;
						if (rxCnt <= BIT_LAST)
							rxSh <= usu_shift(rxSh, msb, rxS);
						else if (ninthOn & (rxCnt == 4'h8))
							rx9 <= rxS;
						if (rxCnt == (ninthOn ? 4'h9 : 4'h8))
						begin
							rxState  <= RX_STOP;
							rxByte   <= rxSh;
							rxDoneEv <= 1'b1;
							feEv     <= rxS != stopLvl;
							peEv     <= parEn & (rx9 != (^rxSh ^ d9));
						end
					end
				end
				RX_STOP:
				begin
					if (rxS != startLvl)
						rxState <= RX_IDLE;
				end
				default:
					rxState <= RX_IDLE;
				endcase
			end
		end

		assign sckEdge = sckS != sckPrev;
		assign lead    = sckS != cpol;
		assign slvBusy = ~modeReg & slaveReg & ~ssS;

		always_ff @(posedge mclk)
		begin
			sDoneEv <= 1'b0;
			if (reset | flush)
			begin
				sckPrev <= 1'b0;
				ssPrev  <= 1'b1;
				misoReg <= 1'b0;
				sCnt    <= 3'h0;
				slvTx   <= 8'h00;
				slvRx   <= 8'h00;
				sByte   <= 8'h00;
			end
			else
			begin
				sckPrev <= sckS;
				ssPrev  <= ssS;
				if (~modeReg & slaveReg & ssPrev & ~ssS)
				begin
					sCnt <= 3'h0;
					if (cpha)
						slvTx <= txDataReg;
					else
					begin
						misoReg <= usu_first(txDataReg, msb);
						slvTx   <= usu_shift(txDataReg, msb, 1'b0);
					end
				end
				else if (slvBusy & sckEdge)
				begin
					if (lead ^ cpha)
					begin
						sCnt  <= sCnt + 3'h1;
						slvRx <= usu_shift(slvRx, msb, mosiS);
						if (sCnt == 3'h7)
						begin
							sDoneEv <= 1'b1;
							sByte   <= usu_shift(slvRx, msb, mosiS);
						end
					end
					else
					begin
						misoReg <= usu_first(slvTx, msb);
						slvTx   <= usu_shift(slvTx, msb, 1'b0);
					end
				end
			end
		end

		assign busy = (txState != TX_IDLE) | (rxState == RX_START) |
			(rxState == RX_BITS) | slvBusy;

		// an event in the clearing cycle wins over the clear
		always_ff @(posedge mclk)
		begin
			if (reset)
			begin
				feReg     <= 1'b0;
				peReg     <= 1'b0;
				rxrReg    <= 1'b0;
				txdReg    <= 1'b0;
				rxDataReg <= DBUF_RESET;
				rtsN[g]   <= 1'b0;
			end
			else
			begin
				if (feEv)
					feReg <= 1'b1;
				else if (wrCsr & ~pwdata[CSR_FE_BIT])
					feReg <= 1'b0;
				if (peEv)
					peReg <= 1'b1;
				else if (wrCsr & ~pwdata[CSR_PE_BIT])
					peReg <= 1'b0;
				if (rxDoneEv | sDoneEv)
					rxrReg <= 1'b1;
				else if (wrCsr & ~pwdata[CSR_RXR_BIT])
					rxrReg <= 1'b0;
				if (txDoneEv | mDoneEv)
					txdReg <= 1'b1;
				else if (wrCsr & ~pwdata[CSR_TXD_BIT])
					txdReg <= 1'b0;
				if (flush)
					rxDataReg <= DBUF_RESET;
				else if (rxDoneEv)
					rxDataReg <= rxByte;
				else if (sDoneEv)
					rxDataReg <= sByte;
				else if (mDoneEv)
					rxDataReg <= mByte;
				// with flow set, peer may send only while a byte can be taken
				rtsN[g] <= flow & ~(rxOnReg & ~rxrReg);
			end
		end

		assign uartTxd[g] = txLine;
		assign sckOut[g]  = sckReg;
		assign mosiOut[g] = mosiReg;
		assign misoOut[g] = misoReg;
		assign sckOeN[g]  = modeReg | slaveReg;
		assign mosiOeN[g] = modeReg | slaveReg;
		assign misoOeN[g] = ~slvBusy;
	end
endmodule : usu_top
`default_nettype wire

// file: usu_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
module usu_top_check
	import usu_pkg::*;
(
	input wire logic        mclk,
	input wire logic        reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [9:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [1:0]  uartTxd,
	input wire logic [1:0]  rtsN,
	input wire logic [1:0]  sckOeN,
	input wire logic [1:0]  mosiOeN
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	logic [1:0] flowReg;
	logic       oeReg;
	logic       wrLand;
	logic       csrWr;
	assign wrLand = psel && penable && pwrite && pready;
	assign csrWr = wrLand && paddr == {CSR_IDX[0], 2'b00};
	// shadows taken from the bus, so no peeking inside the design
	always_ff @(posedge mclk)
	begin
		if (reset)
			flowReg <= 2'b00;
		else
			for (int g = 0; g < 2; g++)
				if (wrLand && paddr == {UCR_IDX[g], 2'b00})
					flowReg[g] <= pwdata[UCR_FLOW_BIT];
	end
	always_ff @(posedge mclk)
	begin
		if (reset)
			oeReg <= 1'b0;
		else if (csrWr)
			oeReg <= pwdata[CSR_MODE_BIT] | pwdata[CSR_SLAVE_BIT];
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		!pready ##1 pready;
	endsequence
	property p_wait_state;
		s_setup |=> s_access;
	endproperty
	a_wait_state: assert property (p_wait_state)
		else $error("pready not after one wait state");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("pready held too long");
	property p_misaligned;
		psel && penable && pready && paddr[1:0] != 2'b00 |-> pslverr;
	endproperty
	a_misaligned: assert property (p_misaligned)
		else $error("misaligned access not refused");
	property p_upper_zero;
		pready |-> prdata[31:8] == 24'h000000;
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("read data upper bits not zero");
	property p_flush_zero;
		pready && !pwrite && paddr == {UCR_IDX[0], 2'b00}
			|-> !prdata[UCR_FLUSH_BIT];
	endproperty
	a_flush_zero: assert property (p_flush_zero)
		else $error("flush bit reads one");
	property p_reset_idle;
		$fell(reset) |-> uartTxd == 2'b11;
	endproperty
	a_reset_idle: assert property (p_reset_idle)
		else $error("serial out not idle after reset");
	property p_rts_noflow;
		(~flowReg & ~$past(flowReg) & rtsN) == 2'b00;
	endproperty
	a_rts_noflow: assert property (p_rts_noflow)
		else $error("request to send raised without flow control");
	property p_oe_mode;
		csrWr |-> ##2 (sckOeN[0] == oeReg && mosiOeN[0] == oeReg);
	endproperty
	a_oe_mode: assert property (p_oe_mode)
		else $error("spi drive enables disagree with mode");
endmodule : usu_top_check
bind usu_top usu_top_check i_usu_top_check (
	.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .uartTxd(uartTxd), .rtsN(rtsN),
	.sckOeN(sckOeN), .mosiOeN(mosiOeN)
);
`default_nettype wire

// file: usu_peer.sv
`timescale 1ns/10ps
`default_nettype none
module usu_peer (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic [1:0] uartTxd,
	input  wire logic [1:0] rtsN,
	input  wire logic [1:0] sckOut,
	input  wire logic [1:0] sckOeN,
	input  wire logic [1:0] mosiOut,
	input  wire logic [1:0] mosiOeN,
	input  wire logic [1:0] misoOut,
	input  wire logic [1:0] misoOeN,
	output logic      [1:0] uartRxd,
	output logic      [1:0] ctsN,
	output logic      [1:0] sckIn,
	output logic      [1:0] mosiIn,
	output logic      [1:0] misoIn
);
	logic togReg;
	// undriven lines wiggle so a stale value never looks valid
	always_ff @(posedge mclk)
	begin
		togReg <= reset ? 1'b0 : ~togReg;
	end
	assign uartRxd = {uartTxd[0], uartTxd[1]};
	assign ctsN = {rtsN[0], rtsN[1]};
	assign sckIn = {sckOeN[0] ? ~sckOut[0] : sckOut[0], togReg};
	assign mosiIn = {mosiOeN[0] ? ~mosiOut[0] : mosiOut[0], togReg};
	assign misoIn = {togReg, misoOeN[1] ? ~misoOut[1] : misoOut[1]};
endmodule : usu_peer
`default_nettype wire

// file: usu_top_test.sv
`timescale 1ns/10ps
`default_nettype none
module usu_top_test
	import usu_pkg::*;
;
	localparam int CS = 0, DB = 1, BD = 2, UC = 3, GC = 4;
	localparam logic [7:0] U0 [9] = '{8'h02, 8'h02, 8'h2a, 8'h2a,
		8'h02, 8'h06, 8'h32, 8'h01, 8'h02};
	localparam logic [7:0] U1 [9] = '{8'h02, 8'h02, 8'h0a, 8'h2a,
		8'h00, 8'h02, 8'h1a, 8'h01, 8'h02};
	localparam logic [7:0] DI [9] = '{8'ha5, 8'h01, 8'h5a, 8'h5a,
		8'h33, 8'h44, 8'h77, 8'h99, 8'h66};
	localparam logic [2:0] FL [9] = '{3'h1, 3'h1, 3'h3, 3'h1,
		3'h5, 3'h1, 3'h3, 3'h1, 3'h0};
	logic        mclk = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        ssSel = 1'b1;
	logic [9:0]  paddr = 10'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, e;
	logic [7:0]  q, g, d;
	logic [1:0]  uartTxd, uartRxd, ctsN, rtsN, sckIn, sckOut, sckOeN;
	logic [1:0]  mosiIn, mosiOut, mosiOeN, misoIn, misoOut, misoOeN;
	int          nMismatch = 0;
	int          checksDone = 0;
	int          t0;
	always #4 mclk = ~mclk;
	usu_top i_usu_top (.mclk(mclk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.uartTxd(uartTxd), .uartRxd(uartRxd), .ctsN(ctsN), .rtsN(rtsN),
		.sckIn(sckIn), .sckOut(sckOut), .sckOeN(sckOeN), .mosiIn(mosiIn),
		.mosiOut(mosiOut), .mosiOeN(mosiOeN), .misoIn(misoIn),
		.misoOut(misoOut), .misoOeN(misoOeN), .ssN({ssSel, 1'b1}));
	usu_peer i_usu_peer (.mclk(mclk), .reset(reset), .uartTxd(uartTxd),
		.rtsN(rtsN), .sckOut(sckOut), .sckOeN(sckOeN), .mosiOut(mosiOut),
		.mosiOeN(mosiOeN), .misoOut(misoOut), .misoOeN(misoOeN),
		.uartRxd(uartRxd), .ctsN(ctsN), .sckIn(sckIn), .mosiIn(mosiIn),
		.misoIn(misoIn));
	task automatic end_of_test;
		if (nMismatch == 0 && checksDone > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test
	task automatic chk(input string n, input logic [31:0] x, y);
		checksDone++;
		if (x !== y)
		begin
			$display("mismatch %s expected %h seen %h", n, x, y);
			nMismatch++;
		end
	endtask : chk
	task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] v);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, v};
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			nMismatch++;
			end_of_test;
		end
	endtask : apb
	function automatic logic [9:0] ad(input int u, k);
		logic [7:0] i;
		i = k == CS ? CSR_IDX[u] : k == DB ? DBUF_IDX[u] : k == BD ?
			BAUD_IDX[u] : k == UC ? UCR_IDX[u] : GCR_IDX[u];
		return {i, 2'b00};
	endfunction : ad
	task automatic wr(input int u, k, input logic [7:0] v);
		apb(1'b1, ad(u, k), v);
	endtask : wr
	task automatic rd(input int u, k);
		apb(1'b0, ad(u, k), 8'h00);
	endtask : rd
	task automatic poll(input int u, b);
		int n;
		n = 0;
		do
		begin
			rd(u, CS);
			n++;
		end
		while (q[b] !== 1'b1 && n < 400);
		if (q[b] !== 1'b1)
		begin
			nMismatch++;
			end_of_test;
		end
	endtask : poll
	initial
	begin
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		for (int u = 0; u < 2; u++)
			for (int k = 0; k < 5; k++)
			begin
				rd(u, k);
				chk("reset value", k == UC ? 8'h02 : 8'h00, q);
			end
		apb(1'b0, 10'h000, 8'h00);
		chk("unmapped", 9'h100, {e, q});
		apb(1'b1, 10'h219, 8'h80);
		chk("misaligned", 1'b1, e);
		wr(0, BD, 8'ha7);
		rd(0, BD);
		chk("mantissa", 8'ha7, q);
		rd(1, BD);
		chk("other unit", 8'h00, q);
		wr(0, BD, 8'h00);
		for (int i = 0; i < 9; i++)
		begin
			wr(1, CS, 8'h80);
			wr(0, CS, 8'h80);
			wr(0, UC, U0[i]);
			wr(1, UC, U1[i]);
			wr(0, GC, i == 1 ? 8'h30 : 8'h10);
			wr(1, GC, 8'h10);
			wr(1, CS, i == 8 ? 8'h80 : 8'hc0);
			rd(1, CS);
			chk("flags cleared", 4'h0, q[4:1]);
			chk("idle level", {~U0[i][0]}, uartTxd[0]);
			wr(0, DB, DI[i]);
			// second stop bit adds 16 clocks
			t0 = $time + (i == 5 ? 128 : 0);
			rd(0, CS);
			chk("busy", 1'b1, q[0]);
			poll(0, 1);
			if (i == 0 || i == 5)
				chk("frame", 1'b1, ($time - t0) / 8 inside {[158:172]});
			rd(0, CS);
			chk("idle", 1'b0, q[0]);
			rd(1, CS);
			chk("rx flags", FL[i], q[4:2]);
			rd(1, DB);
			chk("rx data", i == 1 ? 8'h80 : i == 8 ? 8'h99 : DI[i], q);
		end
		wr(1, CS, 8'h80);
		wr(0, CS, 8'h80);
		wr(0, UC, 8'h42);
		wr(1, UC, 8'h42);
		wr(1, CS, 8'hc0);
		wr(0, DB, 8'h11);
		poll(0, 1);
		chk("stop sending", 1'b1, rtsN[1]);
		wr(0, CS, 8'h80);
		wr(0, DB, 8'h22);
		repeat (250) @(posedge mclk);
		rd(0, CS);
		chk("held by flow", 1'b0, q[1]);
		wr(1, CS, 8'hc0);
		poll(0, 1);
		rd(1, DB);
		chk("flow data", 8'h22, q);
		wr(0, UC, 8'h02);
		wr(1, UC, 8'h02);
		wr(0, CS, 8'h80);
		wr(0, DB, 8'h55);
		wr(0, UC, 8'h82);
		rd(0, UC);
		chk("flush reads", 8'h02, q);
		repeat (200) @(posedge mclk);
		rd(0, CS);
		chk("flushed", 2'b00, q[1:0]);
		chk("flushed line", 1'b1, uartTxd[0]);
		for (int m = 0; m < 4; m++)
		begin
			g = {m[1], m[0], m[0], 5'h10};
			d = 8'h3c ^ 8'(m);
			wr(0, CS, 8'h00);
			wr(1, CS, 8'h20);
			wr(0, GC, g);
			wr(1, GC, g);
			wr(1, DB, ~d);
			chk("clock idle", g[7], sckOut[0]);
			ssSel <= 1'b0;
			repeat (4) @(posedge mclk);
			wr(0, DB, d);
			poll(0, 1);
			rd(1, CS);
			chk("slave flags", 2'b10, q[2:1]);
			rd(0, CS);
			chk("master flags", 1'b0, q[2]);
			rd(1, DB);
			chk("slave rx", d, q);
			rd(0, DB);
			chk("master rx", {~d}, q);
			ssSel <= 1'b1;
		end
		end_of_test;
	end
endmodule : usu_top_test
`default_nettype wire
